// File: verilog/spm_port.sv
// Switch port module: registers, resets, speed, receive and transmit
// Behaviour
// R1 - MAC on every port; coding sublayer only on serial ports.
// R2 - Global select picks configuration 0 or 1, moving attachment.
// R3 - Software addresses ports by port number, not macro index.
// R4 - Macros are programmed by their own index, not port number.
// R5 - 10/100/1000 full duplex; half duplex only at 10 and 100.
// R6 - 2500 full duplex only on ports 24 and 25.
// R7 - All resets set after power-up; one write sets or clears all.
// R8 - Receiver, transmitter, queue resets; PHY or coder resets by attachment.
// R9 - After reconfiguring, software sets then clears the resets.
// R10 - Other fields hold the new value in both writes.
// R11 - Duplex select bit chooses full or half duplex.
// R12 - Wide sampling set at 1G/2.5G, cleared at 10/100.
// R13 - Receive gate clear cuts the frame and drops later ones.
// R14 - Transmit gate clear holds queued frames; current one completes.
// R15 - Configurable gap between transmitted frames.
// R16 - Copper ports follow the PHY speed, others the speed field.
// R17 - Speed field selects 1G at 125 MHz or 100M at 25 MHz.
// R18 - Gigabit on ports 24 and 25 is 1G or 2.5G per transceiver.
// R19 - Speed field also offers 10M with a 2.5 MHz port clock.
// R20 - A held reset stops its path, which restarts idle on release.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module spm_port #(
  parameter int unsigned PORT_NUM = 20
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [spm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [spm_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [spm_pkg::DATA_W-1:0]       reg_rdata,
  input  wire logic                        link_rx_dv,
  input  wire logic [7:0]                  link_rxd,
  input  wire logic [1:0]                  phy_link_speed,
  input  wire logic                        serial_fast_mode,
  output logic                             link_tx_en,
  output logic [7:0]                       link_txd,
  output logic                             iq_valid,
  output logic [7:0]                       iq_data,
  output logic                             iq_end,
  output logic                             iq_abort,
  input  wire logic                        eq_valid,
  input  wire logic [7:0]                  eq_data,
  input  wire logic                        eq_last,
  output logic                             eq_ready,
  output logic                             copper_transceiver_reset,
  output logic                             decoder_reset,
  output logic                             encoder_reset,
  output logic                             coding_sublayer_enable
);
  import spm_pkg::*;

  // ****************************************
  // Attachment decode
  // ****************************************
  function automatic spm_attach_t attach_kind(input int unsigned port, input logic sel);
    if (port <= LAST_COPPER_PORT)
      return ATT_COPPER;
    else if (port >= 20 && port <= FAST_PORT_HI)
      return ATT_SERIAL;
    else if (sel && ((port >= 12 && port <= 16) || port == 18))
      return ATT_SERIAL;
    else if (!sel && port == 16)
      return ATT_SERIAL;
    else
      return ATT_NONE;
  endfunction

  function automatic logic [3:0] macro_index(input int unsigned port, input logic sel);
    if (port <= LAST_COPPER_PORT)
      return 4'(port);
    else if (sel && port >= 12 && port <= 15)
      return 4'h3;
    else if (port == 16)
      return sel ? 4'h2 : 4'h3;
    else if (sel && port == 18)
      return 4'h2;
    else
      return 4'h0;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int PIN_W = 12;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_hold;
  logic             rx_dv_s;
  logic [7:0]       rxd_s;
  logic [1:0]       phy_speed_s;
  logic             fast_s;

  always_ff @(posedge sys_clk)
  begin
    pin_s1 <= {serial_fast_mode, phy_link_speed, link_rx_dv, link_rxd};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // Per bit, so idle noise on data never holds back the valid bit
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pin_hold <= '0;
    else
      pin_hold <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_hold & (pin_s2 ^ pin_s3));
  end

  assign rxd_s       = pin_hold[7:0];
  assign rx_dv_s     = pin_hold[8];
  assign phy_speed_s = pin_hold[10:9];
  assign fast_s      = pin_hold[11];

  // ****************************************
  // Registers
  // ****************************************
  logic [RST_W-1:0] rst_bits;
  logic [1:0]       speed_field;
  logic             duplex_select;
  logic             wide_sampling_select;
  logic             receive_gate;
  logic             transmit_gate;
  logic [GAP_W-1:0] transmit_gap_length;
  logic             port_config_select;

  // Both writes of a reset cycle store the speed too [R9] [R10]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rst_bits    <= RESET_BITS_RST; // [R7]
      speed_field <= SPEED_RST;
    end
    else if (reg_wr && reg_addr == RESET_SPEED_OFS)
    begin
      rst_bits    <= reg_wdata[RST_W-1:0]; // [R7]
      speed_field <= reg_wdata[SPEED_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      duplex_select        <= DUPLEX_RST;
      wide_sampling_select <= WIDE_RST;
    end
    else if (reg_wr && reg_addr == PORT_MODE_OFS)
    begin
      duplex_select        <= reg_wdata[DUPLEX_BIT]; // [R11]
      wide_sampling_select <= reg_wdata[WIDE_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      receive_gate  <= RX_GATE_RST;
      transmit_gate <= TX_GATE_RST;
    end
    else if (reg_wr && reg_addr == PATH_GATE_OFS)
    begin
      receive_gate  <= reg_wdata[RX_GATE_BIT];
      transmit_gate <= reg_wdata[TX_GATE_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      transmit_gap_length <= GAP_RST;
    else if (reg_wr && reg_addr == GAP_CONFIG_OFS)
      transmit_gap_length <= reg_wdata[GAP_W-1:0]; // [R15]
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      port_config_select <= CFG_SEL_RST;
    else if (reg_wr && reg_addr == GLOBAL_MODE_OFS)
      port_config_select <= reg_wdata[CFG_SEL_BIT]; // [R2]
  end

  // ****************************************
  // Attachment, speed and resets
  // ****************************************
  spm_attach_t kind;
  spm_speed_t  eff_speed;
  logic [3:0]  macro_idx;
  logic        fast_link;
  logic        unsupported;
  logic        rst_rx;
  logic        rst_tx;
  logic        rst_queue;

  // Attachment follows the port number [R3]
  assign kind      = attach_kind(PORT_NUM, port_config_select); // [R1] [R2]
  assign macro_idx = macro_index(PORT_NUM, port_config_select); // [R4]

  // Copper follows the PHY [R16] [R17] [R19]
  assign eff_speed = spm_speed_t'((kind == ATT_COPPER) ? phy_speed_s : speed_field);

  // 2.5G only on the two high ports [R6] [R18]
  assign fast_link = (PORT_NUM == FAST_PORT_LO || PORT_NUM == FAST_PORT_HI) &&
                     kind == ATT_SERIAL && eff_speed == SPD_1000 && fast_s;

  // No half duplex at gigabit: both paths shut [R5] [R6]
  assign unsupported = !duplex_select && (eff_speed == SPD_1000 || eff_speed == 2'b11);

  assign rst_rx    = rst_bits[RST_RX_BIT];    // [R8]
  assign rst_tx    = rst_bits[RST_TX_BIT];    // [R8]
  assign rst_queue = rst_bits[RST_QUEUE_BIT]; // [R8]

  // A reset exists only with its block [R8] [R1]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      copper_transceiver_reset <= 1'b0;
      decoder_reset            <= 1'b0;
      encoder_reset            <= 1'b0;
      coding_sublayer_enable   <= 1'b0;
    end
    else
    begin
      copper_transceiver_reset <= (kind == ATT_COPPER) && rst_bits[RST_COPPER_BIT]; // [R8]
      decoder_reset            <= (kind == ATT_SERIAL) && rst_bits[RST_DEC_BIT];    // [R8]
      encoder_reset            <= (kind == ATT_SERIAL) && rst_bits[RST_ENC_BIT];    // [R8]
      coding_sublayer_enable   <= (kind == ATT_SERIAL);                            // [R1]
    end
  end

  logic tick;

  spm_rate_gen u_rate_gen (
    .sys_clk (sys_clk),
    .reset   (reset),
    .speed   (eff_speed),
    .fast    (fast_link),
    .tick    (tick)
  );

  // ****************************************
  // Receive path
  // ****************************************
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RECV = 2'b01,
    RX_DROP = 2'b10
  } spm_rx_state_t;

  spm_rx_state_t rx_state;
  logic          rx_half;
  logic [3:0]    rx_low;
  logic          rx_run;

  assign rx_run = receive_gate && !unsupported;

  always_ff @(posedge sys_clk)
  begin
    if (reset || rst_rx || rst_queue)
    begin
      rx_state <= RX_IDLE; // [R20]
      rx_half  <= 1'b0;
      rx_low   <= 4'h0;
      iq_valid <= 1'b0;
      iq_data  <= 8'h00;
      iq_end   <= 1'b0;
      iq_abort <= 1'b0;
    end
    else
    begin
      iq_valid <= 1'b0;
      iq_end   <= 1'b0;
      iq_abort <= 1'b0;
      if (tick)
      begin
        case (rx_state)
          RX_IDLE:
          begin
            rx_half <= 1'b0;
            if (rx_dv_s)
              rx_state <= rx_run ? RX_RECV : RX_DROP; // [R13]
            if (rx_dv_s && rx_run)
            begin
              // Wide: a byte per tick, else low nibble first [R12]
              if (wide_sampling_select)
              begin
                iq_data  <= rxd_s;
                iq_valid <= 1'b1;
              end
              else
              begin
                rx_low  <= rxd_s[3:0];
                rx_half <= 1'b1;
              end
            end
          end
          RX_RECV:
          begin
            if (!rx_run)
            begin
              iq_abort <= 1'b1; // [R13]
              rx_state <= rx_dv_s ? RX_DROP : RX_IDLE;
            end
            else if (!rx_dv_s)
            begin
              iq_end   <= 1'b1;
              rx_state <= RX_IDLE;
            end
            else if (wide_sampling_select) // [R12]
            begin
              iq_data  <= rxd_s;
              iq_valid <= 1'b1;
            end
            else if (!rx_half)
            begin
              rx_low  <= rxd_s[3:0];
              rx_half <= 1'b1;
            end
            else
            begin
              iq_data  <= {rxd_s[3:0], rx_low};
              iq_valid <= 1'b1;
              rx_half  <= 1'b0;
            end
          end
          RX_DROP:
          begin
            if (!rx_dv_s)
              rx_state <= RX_IDLE; // [R13]
          end
          default:
            rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_GAP  = 2'b10
  } spm_tx_state_t;

  spm_tx_state_t    tx_state;
  logic             tx_half;
  logic             tx_last;
  logic [7:0]       tx_byte;
  logic [GAP_W-1:0] gap_cnt;
  logic             byte_end;
  logic             byte_free;
  logic             tx_hold;

  assign tx_hold  = rst_tx || rst_queue;
  assign byte_end = wide_sampling_select || tx_half;

  // Gate is checked only at frame start, so a frame in flight completes [R14]
  // Half duplex defers to receive carrier [R11]
  always_comb
  begin
    case (tx_state)
      TX_IDLE: byte_free = transmit_gate && !unsupported && (duplex_select || !rx_dv_s); // [R14]
      TX_SEND: byte_free = byte_end && !tx_last;
      default: byte_free = 1'b0;
    endcase
  end

  assign eq_ready = tick && eq_valid && byte_free && !tx_hold && !reset; // [R20]

  always_ff @(posedge sys_clk)
  begin
    if (reset || tx_hold)
    begin
      tx_state   <= TX_IDLE; // [R20]
      tx_half    <= 1'b0;
      tx_last    <= 1'b0;
      tx_byte    <= 8'h00;
      gap_cnt    <= '0;
      link_tx_en <= 1'b0;
      link_txd   <= 8'h00;
    end
    else if (tick)
    begin
      if (eq_ready)
      begin
        tx_state   <= TX_SEND;
        tx_byte    <= eq_data;
        tx_last    <= eq_last;
        tx_half    <= 1'b0;
        link_tx_en <= 1'b1;
        link_txd   <= wide_sampling_select ? eq_data : {4'h0, eq_data[3:0]}; // [R12]
      end
      else
      begin
        case (tx_state)
          TX_SEND:
          begin
            if (!byte_end)
            begin
              link_txd <= {4'h0, tx_byte[7:4]};
              tx_half  <= 1'b1;
            end
            else
            begin
              // Last byte or underrun: close the frame, then the gap [R15]
              link_tx_en <= 1'b0;
              link_txd   <= 8'h00;
              gap_cnt    <= transmit_gap_length;
              tx_state   <= TX_GAP;
            end
          end
          TX_GAP:
          begin
            if (gap_cnt <= GAP_W'(1))
              tx_state <= TX_IDLE; // [R15]
            else
              gap_cnt <= gap_cnt - GAP_W'(1);
          end
          default:
            tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset || !reg_rd)
      reg_rdata <= '0;
    else
    begin
      reg_rdata <= '0;
      case (reg_addr)
        RESET_SPEED_OFS:
        begin
          reg_rdata[RST_W-1:0]       <= rst_bits;
          reg_rdata[SPEED_LSB +: 2] <= speed_field;
        end
        PORT_MODE_OFS:
        begin
          reg_rdata[DUPLEX_BIT] <= duplex_select;
          reg_rdata[WIDE_BIT]   <= wide_sampling_select;
        end
        PATH_GATE_OFS:
        begin
          reg_rdata[RX_GATE_BIT] <= receive_gate;
          reg_rdata[TX_GATE_BIT] <= transmit_gate;
        end
        GAP_CONFIG_OFS:  reg_rdata[GAP_W-1:0] <= transmit_gap_length;
        GLOBAL_MODE_OFS: reg_rdata[CFG_SEL_BIT] <= port_config_select;
        PORT_STATUS_OFS:
        begin
          reg_rdata[ST_KIND_LSB +: 2]  <= kind;
          reg_rdata[ST_SPEED_LSB +: 2] <= eff_speed;
          reg_rdata[ST_FAST_BIT]       <= fast_link;
          reg_rdata[ST_UNSUP_BIT]      <= unsupported;
          reg_rdata[ST_MACRO_LSB +: 4] <= macro_idx; // [R4]
          reg_rdata[ST_RX_BUSY_BIT]    <= (rx_state != RX_IDLE);
          reg_rdata[ST_TX_BUSY_BIT]    <= (tx_state != TX_IDLE);
        end
        default: reg_rdata <= '0;
      endcase
    end
  end

endmodule // spm_port
`default_nettype wire

// File: verilog/spm_pkg.sv
// Constants, fields and types of the switch port module
package spm_pkg;

  // ************************************************************
  // Register bus and offsets
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] RESET_SPEED_OFS = 8'h00;
  localparam logic [7:0] PORT_MODE_OFS   = 8'h04;
  localparam logic [7:0] PATH_GATE_OFS   = 8'h08;
  localparam logic [7:0] GAP_CONFIG_OFS  = 8'h0c;
  localparam logic [7:0] GLOBAL_MODE_OFS = 8'h10;
  localparam logic [7:0] PORT_STATUS_OFS = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int RST_RX_BIT     = 0;
  localparam int RST_TX_BIT     = 1;
  localparam int RST_QUEUE_BIT  = 2;
  localparam int RST_COPPER_BIT = 3;
  localparam int RST_DEC_BIT    = 4;
  localparam int RST_ENC_BIT    = 5;
  localparam int RST_W          = 6;
  localparam int SPEED_LSB      = 8;
  localparam int DUPLEX_BIT     = 0;
  localparam int WIDE_BIT       = 4;
  localparam int RX_GATE_BIT    = 0;
  localparam int TX_GATE_BIT    = 4;
  localparam int GAP_W          = 5;
  localparam int CFG_SEL_BIT    = 0;
  localparam int ST_KIND_LSB    = 0;
  localparam int ST_SPEED_LSB   = 4;
  localparam int ST_FAST_BIT    = 6;
  localparam int ST_UNSUP_BIT   = 7;
  localparam int ST_MACRO_LSB   = 8;
  localparam int ST_RX_BUSY_BIT = 12;
  localparam int ST_TX_BUSY_BIT = 13;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [RST_W-1:0] RESET_BITS_RST  = 6'h3f;
  localparam logic [1:0]       SPEED_RST       = 2'h2;
  localparam logic             DUPLEX_RST      = 1'b1;
  localparam logic             WIDE_RST        = 1'b1;
  localparam logic             RX_GATE_RST     = 1'b0;
  localparam logic             TX_GATE_RST     = 1'b0;
  localparam logic [GAP_W-1:0] GAP_RST         = 5'h0c;
  localparam logic             CFG_SEL_RST     = 1'b0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } spm_speed_t;

  typedef enum logic [1:0] {
    ATT_NONE   = 2'b00,
    ATT_COPPER = 2'b01,
    ATT_SERIAL = 2'b10
  } spm_attach_t;

  localparam int unsigned LAST_COPPER_PORT = 11;
  localparam int unsigned FAST_PORT_LO     = 24;
  localparam int unsigned FAST_PORT_HI     = 25;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned SYS_CLK_KHZ = 250000;
  localparam int unsigned PORT_KHZ_10   = 2500;
  localparam int unsigned PORT_KHZ_100  = 25000;
  localparam int unsigned PORT_KHZ_1000 = 125000;
  localparam int unsigned PORT_KHZ_2500 = 312500;

  // Period rounds down, at least one cycle
  function automatic int unsigned cycles_of(input int unsigned khz);
    int unsigned q;
    q = SYS_CLK_KHZ / khz;
    return (q < 1) ? 1 : q;
  endfunction

  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_10   = DIV_W'(cycles_of(PORT_KHZ_10));
  localparam logic [DIV_W-1:0] DIV_100  = DIV_W'(cycles_of(PORT_KHZ_100));
  localparam logic [DIV_W-1:0] DIV_1000 = DIV_W'(cycles_of(PORT_KHZ_1000));
  localparam logic [DIV_W-1:0] DIV_2500 = DIV_W'(cycles_of(PORT_KHZ_2500));

endpackage

// File: verilog/spm_rate_gen.sv
// Port clock enable: one-cycle tick at the link rate, but every cycle at 2.5G
`timescale 1ns/10ps
`default_nettype none
module spm_rate_gen (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire spm_pkg::spm_speed_t speed,
  input  wire logic               fast,
  output logic                    tick
);
  import spm_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  always_comb
  begin
    case (speed)
      SPD_10:   limit = DIV_10;
      SPD_100:  limit = DIV_100;
      SPD_1000: limit = fast ? DIV_2500 : DIV_1000;
      default:  limit = DIV_1000;
    endcase
  end

  // No restart on speed change: the counter catches up
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else if (count + DIV_W'(1) >= limit)
    begin
      count <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + DIV_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule // spm_rate_gen
`default_nettype wire

// File: tb/spm_port_properties.sv
// Port-level checks of the switch port module
`timescale 1ns/10ps
`default_nettype none
module spm_port_properties (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        iq_valid,
  input wire logic        iq_abort,
  input wire logic        iq_end,
  input wire logic        eq_valid,
  input wire logic        eq_ready,
  input wire logic        link_tx_en,
  input wire logic        copper_transceiver_reset,
  input wire logic        decoder_reset
);
  import spm_pkg::*;
  logic [2:0] rst_bits;
  logic       tx_open;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadows of path resets and transmit gate
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rst_bits <= 3'h7;
    else if (reg_wr && reg_addr == RESET_SPEED_OFS)
      rst_bits <= reg_wdata[2:0];
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      tx_open <= 1'b0;
    else if (reg_wr && reg_addr == PATH_GATE_OFS)
      tx_open <= reg_wdata[TX_GATE_BIT];
  end
  attach_resets_a: assert property (!(copper_transceiver_reset && decoder_reset))
    else $error("both attach resets high");
  boot_reset_a: assert property ($fell(reset) |-> ##[1:2] (decoder_reset || copper_transceiver_reset))
    else $error("resets not set after power-up");
  rx_held_a: assert property ((rst_bits[0] || rst_bits[2]) && $past(rst_bits[0] || rst_bits[2]) |-> !iq_valid)
    else $error("rx output in reset");
  tx_held_a: assert property (rst_bits[1] || rst_bits[2] |-> !eq_ready)
    else $error("tx take in reset");
  gate_hold_a: assert property (!tx_open && !link_tx_en |-> !eq_ready)
    else $error("tx start with gate closed");
  take_valid_a: assert property (eq_ready |-> eq_valid)
    else $error("take without valid");
  cut_frame_a: assert property (iq_abort |=> (!iq_abort && !iq_valid) [*3])
    else $error("rx after cut");
  tx_gap_a: assert property ($fell(link_tx_en) |-> !link_tx_en [*2])
    else $error("no transmit gap");
  cover property (iq_abort);
  cover property (iq_end);
  cover property ($fell(link_tx_en));
endmodule // spm_port_properties
bind spm_port spm_port_properties u_props (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .iq_valid,
  .iq_abort, .iq_end, .eq_valid, .eq_ready, .link_tx_en, .copper_transceiver_reset, .decoder_reset);
`default_nettype wire

// File: tb/spm_phy_model.sv
// Link partner: sends frames, tallies transmit
`timescale 1ns/10ps
`default_nettype none
module spm_phy_model (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       link_tx_en,
  input  wire logic [7:0] link_txd,
  output logic            link_rx_dv,
  output logic [7:0]      link_rxd,
  output int              tx_cyc,
  output logic [7:0]      tx_first
);
  logic [8:0] cnt = 9'h0;
  logic [7:0] idle = 8'h5a;
  logic       was_tx = 1'b0;
  initial tx_cyc = 0;
  // Bytes count down to 1, two cycles each for the synchroniser
  assign link_rx_dv = cnt != 9'h0;
  assign link_rxd   = link_rx_dv ? 8'((cnt + 9'h1) >> 1) : idle;
  always @(posedge sys_clk)
  begin
    idle <= ~idle; // Idle line never shows a stale byte
    if (cnt != 9'h0)
      cnt <= cnt - 9'h1;
    else if (go)
      cnt <= {len, 1'b0};
    if (link_tx_en && !was_tx)
      tx_first <= link_txd;
    tx_cyc <= tx_cyc + int'(link_tx_en);
    was_tx <= link_tx_en;
  end
endmodule // spm_phy_model
`default_nettype wire

// File: tb/spm_port_tb.sv
// Self-checking bench for the switch port module
`timescale 1ns/10ps
`default_nettype none
module spm_port_tb;
  import spm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  len = 8'h00;
  logic [7:0]  eq_left = 8'h00;
  logic [31:0] reg_rdata, rv;
  logic        link_rx_dv, link_tx_en, iq_valid, iq_end, iq_abort, eq_ready, eq_valid, eq_last;
  logic        copper_transceiver_reset, decoder_reset, encoder_reset, coding_sublayer_enable;
  logic [7:0]  link_rxd, link_txd, iq_data, eq_data, tx_first, last_iq;
  int          tx_cyc, n0, t0, err_total = 0, n_tests = 0, n_iq = 0, n_end = 0, n_ab = 0;
  logic [31:0] exp_rst [7] = '{32'h23f, 32'h11, 32'h0, 32'h0c, 32'h0, 32'h22, 32'h0};
  always #2 sys_clk = ~sys_clk;
  // Egress queue: frames of three bytes, counted down
  assign eq_valid = eq_left != 8'h00;
  assign eq_data  = eq_left;
  assign eq_last  = eq_left == 8'h01 || eq_left == 8'h04;
  always @(posedge sys_clk)
  begin
    if (eq_ready === 1'b1)
      eq_left <= eq_left - 8'h01;
    if (iq_valid === 1'b1)
    begin
      n_iq++;
      last_iq = iq_data;
    end
    n_end += int'(iq_end === 1'b1);
    n_ab += int'(iq_abort === 1'b1);
  end
  spm_port DUT (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_rx_dv,
    .link_rxd, .phy_link_speed(2'h2), .serial_fast_mode(1'b0), .link_tx_en, .link_txd, .iq_valid,
    .iq_data, .iq_end, .iq_abort, .eq_valid, .eq_data, .eq_last, .eq_ready, .copper_transceiver_reset,
    .decoder_reset, .encoder_reset, .coding_sublayer_enable);
  spm_phy_model u_phy (.sys_clk, .go, .len, .link_tx_en, .link_txd, .link_rx_dv, .link_rxd, .tx_cyc,
    .tx_first);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic frame(input logic [7:0] l, input int w);
    @(posedge sys_clk);
    {go, len} <= {1'b1, l};
    @(posedge sys_clk);
    go <= 1'b0;
    cyc(w);
  endtask
  task automatic load(input logic [7:0] n);
    @(posedge sys_clk);
    eq_left <= n;
  endtask
  task automatic wait_tx();
    int i;
    for (i = 0; i < 3000 && (eq_left !== 8'h00 || link_tx_en !== 1'b0); i++)
      @(posedge sys_clk);
    if (i == 3000)
    begin
      err_total++;
      end_of_test();
    end
    cyc(40);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(8);
    reset <= 1'b0;
    wr(8'h18, 32'hffffffff);
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(4 * i), rv);
      chk("reset value", exp_rst[i], rv);
    end
    chk("sublayer", 32'h1, coding_sublayer_enable);
    chk("port resets", 32'h3, {copper_transceiver_reset, decoder_reset, encoder_reset});
    wr(GLOBAL_MODE_OFS, 32'h1);
    rd(PORT_STATUS_OFS, rv);
    chk("mapping", 32'h22, rv);
    $display("test mapping done");
    wr(RESET_SPEED_OFS, 32'h23f);
    wr(RESET_SPEED_OFS, 32'h200);
    cyc(2);
    chk("resets cleared", 32'h0, {decoder_reset, encoder_reset});
    wr(GAP_CONFIG_OFS, 32'h2);
    wr(PATH_GATE_OFS, 32'h11);
    n0 = n_iq;
    frame(8'd4, 40);
    chk("rx bytes", n0 + 4, n_iq);
    chk("rx last", 32'h1, last_iq);
    chk("rx end", 32'h1, n_end);
    n0 = n_iq;
    frame(8'd40, 30);
    wr(PATH_GATE_OFS, 32'h10);
    cyc(100);
    chk("rx cut", 32'h1, n_ab);
    chk("rx dropped", 32'h1, n_iq - n0 < 40);
    wr(PATH_GATE_OFS, 32'h11);
    $display("test receive done");
    t0 = tx_cyc;
    load(8'd6);
    wait_tx();
    chk("tx cycles", t0 + 12, tx_cyc);
    chk("tx first", 32'h3, tx_first);
    wr(PATH_GATE_OFS, 32'h01);
    load(8'd3);
    cyc(100);
    chk("tx held", 32'h3, eq_left);
    wr(PATH_GATE_OFS, 32'h11);
    wait_tx();
    chk("tx drained", 32'h0, eq_left);
    $display("test transmit done");
    wr(RESET_SPEED_OFS, 32'h207);
    n0 = n_iq;
    load(8'd3);
    frame(8'd4, 60);
    chk("rx in reset", n0, n_iq);
    chk("tx in reset", 32'h3, eq_left);
    wr(RESET_SPEED_OFS, 32'h200);
    wait_tx();
    chk("tx after reset", 32'h0, eq_left);
    wr(PORT_MODE_OFS, 32'h10);
    rd(PORT_STATUS_OFS, rv);
    chk("half at 1g", 32'ha2, rv);
    wr(PORT_MODE_OFS, 32'h11);
    for (int s = 0; s < 3; s++)
    begin
      wr(RESET_SPEED_OFS, 32'h3f | (s << 8));
      wr(PORT_MODE_OFS, (s == 2) ? 32'h11 : 32'h01);
      wr(RESET_SPEED_OFS, s << 8);
      rd(PORT_STATUS_OFS, rv);
      chk("speed", 32'h02 | (s << 4), rv);
    end
    $display("test speeds done");
    end_of_test();
  end
endmodule // spm_port_tb
`default_nettype wire
